// [dv/prmd_rc_filter.sv]
/* Filter model: the charge on each output's RC network, kept as high cycles since the last clear.
   Assumes one sample of every pin at each rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module prmd_rc_filter
(
    input  wire logic             clock,
    input  wire logic             clear,
    input  wire logic [3:0]       pin,
    output var  logic [3:0][10:0] charge
);
    always_ff @(posedge clock)
    begin
        for (int c = 0; c < 4; c++)
            charge[c] <= clear ? 11'h000 : charge[c] + 11'(pin[c]);
    end
endmodule
`default_nettype wire

// [dv/prmd_top_chk.sv]
/* Checker for prmd_top: bus answers, read fields and the outputs after reset.
   Assumes the single clock domain of the top module. */
`timescale 1ns/10ps
`default_nettype none
module prmd_top_chk
    import prmd_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              clock,
    input wire logic              resetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [3:0]        pwmOut
);
    logic [ADDR_W-3:0] rdIdx;
    wire logic         isWeight;
    wire logic         unmapped;
    assign isWeight = rdIdx == IDX_WEIGHT_CH0 || rdIdx == IDX_WEIGHT_CH1
                   || rdIdx == IDX_WEIGHT_CH2 || rdIdx == IDX_WEIGHT_CH3;
    assign unmapped = rdIdx < IDX_WEIGHT_CH0 || rdIdx > IDX_STATUS;
    // The read address is kept so that the answer can be judged against it.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rdIdx <= '0;
        else if (s_axi_arvalid && s_axi_arready)
            rdIdx <= s_axi_araddr[ADDR_W-1:2];
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    a_pins_reset: assert property ($rose(resetn) |-> (pwmOut == 4'h0) [*2]) else $error("pins not low");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("no write answer");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer stays");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stays");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
    a_fixed_one: assert property (s_axi_rvalid && isWeight |-> s_axi_rdata[7] && s_axi_rresp == RESP_OKAY)
        else $error("weight bit 7 not one");
    a_unmapped_err: assert property (s_axi_rvalid && unmapped |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:20] == 12'h000) else $error("upper bits set");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_unmapped: cover property (s_axi_rvalid && unmapped);
    c_pulse: cover property ($rose(pwmOut[0]));
endmodule
bind prmd_top prmd_top_chk #(.ADDR_W(ADDR_W)) i_prmd_top_chk (.clock, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwmOut);
`default_nettype wire

// [dv/tb_pwm_rate_multiplier_dac.sv]
/* Bench for prmd_top: AXI4-Lite register tasks, then duty tests on all four outputs.
   Assumes the bound checker and the filter model. */
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_rate_multiplier_dac
    import prmd_pkg::*;
;
    logic             clock;
    logic             resetn = 1'b0;
    logic [11:0]      s_axi_awaddr = 12'h000;
    logic             s_axi_awvalid = 1'b0;
    logic             s_axi_awready;
    logic [31:0]      s_axi_wdata = 32'h0;
    logic [3:0]       s_axi_wstrb = 4'hF;
    logic             s_axi_wvalid = 1'b0;
    logic             s_axi_wready;
    logic [1:0]       s_axi_bresp;
    logic             s_axi_bvalid;
    logic             s_axi_bready = 1'b0;
    logic [11:0]      s_axi_araddr = 12'h000;
    logic             s_axi_arvalid = 1'b0;
    logic             s_axi_arready;
    logic [31:0]      s_axi_rdata;
    logic [1:0]       s_axi_rresp;
    logic             s_axi_rvalid;
    logic             s_axi_rready = 1'b0;
    logic [3:0]       pwmOut;
    logic             clear = 1'b0;
    logic [3:0][10:0] charge;
    int               error_cnt = 0;
    int               check_count = 0;
    logic [31:0]      rdv;
    logic [9:0]       cnt1;
    logic [1:0]       resp;
    realtime          tAr;
    realtime          tAr1;
    logic [11:0]      wa [4] = '{12'h1D0, 12'h1D8, 12'h1DC, 12'h1E4};
    logic [7:0]       wt [2][4] = '{'{8'h00, 8'h3F, 8'h18, 8'h40}, '{8'h05, 8'h05, 8'h05, 8'h45}};
    logic [7:0]       fn [2][2] = '{'{8'hF0, 8'h06}, '{8'h21, 8'h84}};
    logic [10:0]      ex [2][4] = '{'{11'h000, 11'h3FF, 11'h186, 11'h400}, '{11'h051, 11'h052, 11'h054, 11'h3A8}};

    prmd_top i_prmd_top
    (
        .clock, .resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pwmOut
    );
    prmd_rc_filter i_prmd_rc_filter
    (
        .clock, .clear, .pin(pwmOut), .charge
    );

    initial
    begin
        clock = 1'b0;
        forever
            #10 clock = ~clock;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic tick(inout int n);
        @(posedge clock);
        n++;
        if (n > 100)
        begin
            error_cnt++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            tick(n);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            tick(n);
            if (s_axi_arready && s_axi_arvalid)
            begin
                s_axi_arvalid <= 1'b0;
                tAr = $realtime;
            end
        end
        while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk({28'h0, pwmOut}, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            rd({IDX_WEIGHT_CH0 + 10'(i), 2'b00});
            chk(rdv, (i == 1 || i == 4) ? 32'h00 : 32'h80);
        end
        $display("reset test done");
        wr(12'h1D0, 8'h15);
        rd(12'h1D0);
        chk(rdv, 32'h95);
        s_axi_wstrb <= 4'h0;
        wr(12'h1D0, 8'h3A);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        s_axi_wstrb <= 4'hF;
        rd(12'h1D0);
        chk(rdv, 32'h95);
        wr(12'h1D4, 8'hA5);
        rd(12'h1D4);
        chk(rdv, 32'hA5);
        wr(12'h100, 8'h5A);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(12'h1EC);
        chk({rdv[29:0], resp}, {30'h0, RESP_SLVERR});
        rd(12'h1E8);
        cnt1 = rdv[9:0];
        tAr1 = tAr;
        rd(12'h1E8);
        chk({22'h0, rdv[9:0] - cnt1}, 32'(int'((tAr - tAr1) / 20.0)));
        $display("register test done");
        // A whole 1024-cycle frame is counted, so the result does not depend on where the frame starts.
        for (int p = 0; p < 2; p++)
        begin
            for (int c = 0; c < 4; c++)
                wr(wa[c], wt[p][c]);
            wr(12'h1D4, fn[p][0]);
            wr(12'h1E0, fn[p][1]);
            repeat (3) @(posedge clock);
            clear <= 1'b1;
            @(posedge clock);
            clear <= 1'b0;
            repeat (1024) @(posedge clock);
            #1;
            for (int c = 0; c < 4; c++)
                chk({21'h0, charge[c]}, {21'h0, ex[p][c]});
            if (p == 0)
            begin
                rd({IDX_STATUS, 2'b00});
                chk({30'h0, rdv[STATUS_LEVEL_LSB + 3], rdv[STATUS_LEVEL_LSB]}, 32'h2);
            end
            $display("duty test %0d done", p);
        end
        complete_run();
    end
endmodule
`default_nettype wire

// [verilog/prmd_channel.sv]
/*
 * One output channel: compares the shared pulse count with the channel's
 * weight, stretches selected intervals by one clock and applies polarity.
 * Assumes the shared counter and the register fields come from the top.
 */
`timescale 1ns/10ps
`default_nettype none

module prmd_channel
    import prmd_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  resetn,
    input  wire logic [PULSE_W-1:0]    pulseCount,
    input  wire logic [INTERVAL_W-1:0] interval,
    input  wire logic [PULSE_W-1:0]    weight,
    input  wire logic [FINE_W-1:0]     fineStep,
    input  wire logic                  invert,
    output var  logic                  level
);

    logic stretch;
    logic inPulse;
    logic inExtra;
    logic next_level;

    // The extra clock sits at the match count, so a stretched pulse ends one later.
    assign stretch    = prmd_stretch(interval, fineStep); // R07 R08 R17
    assign inPulse    = pulseCount < weight; // R02 R03 R14
    assign inExtra    = stretch & (pulseCount == weight); // R05 R06
    assign next_level = (inPulse | inExtra) ^ invert; // R13 R09 R10

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            level <= 1'b0; // R04
        end
        else
        begin
            level <= next_level;
        end
    end

endmodule

`default_nettype wire

// [verilog/prmd_pkg.sv]
/*
 * Shared constants for the four-channel pulse-width and fine-step generator:
 * register indices, field layouts, reset values, counter widths and the
 * fine-step interval decoder.
 * Assumes it is compiled before every module that imports it.
 */
`default_nettype none

package prmd_pkg;

    // Counter layout: low bits time the pulse, high bits number the interval.
    localparam int COUNT_W    = 10;
    localparam int PULSE_W    = 6;
    localparam int INTERVAL_W = 4;
    localparam int FINE_W     = 4;
    localparam int CHANNELS   = 4;
    localparam int FINE_REGS  = 2;

    // Register indices; the bus byte address is four times the index.
    localparam logic [9:0] IDX_WEIGHT_CH0  = 10'h074;
    localparam logic [9:0] IDX_FINE_CH1_0  = 10'h075;
    localparam logic [9:0] IDX_WEIGHT_CH1  = 10'h076;
    localparam logic [9:0] IDX_WEIGHT_CH2  = 10'h077;
    localparam logic [9:0] IDX_FINE_CH3_2  = 10'h078;
    localparam logic [9:0] IDX_WEIGHT_CH3  = 10'h079;
    localparam logic [9:0] IDX_STATUS      = 10'h07A;

    // Pulse-weight register fields.
    localparam int WEIGHT_FIXED_BIT  = 7;
    localparam int WEIGHT_INVERT_BIT = 6;
    localparam logic [7:0] WEIGHT_RESET = 8'h80;
    localparam logic [7:0] FINE_RESET   = 8'h00;

    // Status register fields.
    localparam int STATUS_LEVEL_LSB = 16;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Fine-step interval codes.
    localparam logic [3:0] INTERVAL_MID   = 4'h8;
    localparam logic [2:0] INTERVAL_QUART = 3'h4;
    localparam logic [1:0] INTERVAL_EIGHT = 2'h2;

    typedef enum logic [0:0]
    {
        RS_IDLE = 1'b0,
        RS_DATA = 1'b1
    } prmd_rstate_t;

    // Each fine-step bit adds its own interval set; interval 0 is never chosen.
    function automatic logic prmd_stretch(input logic [3:0] interval, input logic [3:0] fine);
        logic hit;
        hit = 1'b0;
        hit = hit | (fine[0] & (interval == INTERVAL_MID));
        hit = hit | (fine[1] & (interval[2:0] == INTERVAL_QUART));
        hit = hit | (fine[2] & (interval[1:0] == INTERVAL_EIGHT));
        hit = hit | (fine[3] & interval[0]);
        return hit;
    endfunction

endpackage

`default_nettype wire

// [verilog/prmd_top.sv]
/*
 * Four-channel pulse-width generator with fine-step stretching, used as a
 * DAC behind external RC filters, with an AXI4-Lite register slave.
 * Assumes a single clock, synchronous bus masters and dedicated output pins.
 */
// Our own choice: the AXI4-Lite slave port.
// Summary of operation
// R01: One shared 10-bit counter increments every clock for all channels.
// R02: Low six counter bits overflowing sets every active channel's output.
// R03: Low six bits matching a channel's weight resets that channel's output.
// R04: After reset every channel pin is driven low, never floating.
// R05: Selected intervals lengthen the pulse by one clock at its start; the code adds that clock at its end, at the match count.
// R06: Each added increment lasts exactly one clock period.
// R07: Fine-step bits select intervals 8; 4,12; 2,6,10,14; odd; bits add.
// R08: Interval zero is never stretched; fine step zero stretches nothing.
// R09: Weight and fine step zero with normal polarity keep output low.
// R10: Weight 3Fh, fine step 0Fh: high always except one clock in interval 0.
// R11: Software makes a static high by clearing both values and inverting.
// R12: Weight register bit 7 always reads one; reset value reads 80h.
// R13: Bit 6 inverts polarity: set means low during pulse, high after.
// R14: Weight register bits 5 to 0 hold the compared pulse width.
// R15: Each fine-step register holds two channels, low nibble lower channel.
// R16: Weight and fine step form one 10-bit code, weight on top.
// R17: Interval number is the upper four bits of the shared counter.
`timescale 1ns/10ps
`default_nettype none

module prmd_top
    import prmd_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output wire logic [CHANNELS-1:0] pwmOut
);

    // Shared counter and channel settings.
    logic [COUNT_W-1:0]    count;
    logic [COUNT_W-1:0]    next_count;
    logic [PULSE_W:0]      weight [CHANNELS];
    logic [7:0]            fine [FINE_REGS];
    logic [FINE_W-1:0]     chanFine [CHANNELS];
    logic [PULSE_W-1:0]    chanWeight [CHANNELS];
    logic [CHANNELS-1:0]   chanInvert;

    // Write channel state.
    logic                  awHeld;
    logic                  wHeld;
    logic [ADDR_W-1:0]     awAddr;
    logic [7:0]            wByte;
    logic                  wLane;
    logic                  awTake;
    logic                  wTake;
    logic                  haveAw;
    logic                  haveW;
    logic                  wrDo;
    logic [ADDR_W-1:0]     wrAddr;
    logic [7:0]            wrByte;
    logic                  wrLane;
    logic [9:0]            wrIndex;
    logic                  wrHit;
    logic                  next_awHeld;
    logic                  next_wHeld;
    logic                  next_bvalid;
    logic                  wrStore;
    logic [CHANNELS-1:0]   wrWeight;
    logic [FINE_REGS-1:0]  wrFine;

    // Read channel state.
    prmd_rstate_t          rdState;
    prmd_rstate_t          next_rdState;
    logic                  arTake;
    logic [9:0]            rdIndex;
    logic                  rdHit;
    logic [31:0]           rdWord;

    // Index decoding shared by both channels.
    function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] addr);
        return 10'(addr[ADDR_W-1:2]);
    endfunction

    function automatic logic is_mapped(input logic [9:0] idx);
        return (idx == IDX_WEIGHT_CH0) | (idx == IDX_FINE_CH1_0) | (idx == IDX_WEIGHT_CH1)
             | (idx == IDX_WEIGHT_CH2) | (idx == IDX_FINE_CH3_2) | (idx == IDX_WEIGHT_CH3)
             | (idx == IDX_STATUS);
    endfunction

    function automatic logic [FINE_W-1:0] fine_nibble(input logic [7:0] value, input logic upper);
        return upper ? value[FINE_W +: FINE_W] : value[FINE_W-1:0];
    endfunction

    // Bit 7 has no storage behind it; it is forced at the read mux instead.
    function automatic logic [7:0] weight_readback(input logic [PULSE_W:0] value);
        logic [7:0] readback;
        readback                   = 8'(value);
        readback[WEIGHT_FIXED_BIT] = 1'b1;
        return readback;
    endfunction

    // The counter never stops, so all channels share one frame phase.
    assign next_count = COUNT_W'(count + 1'b1); // R01

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count; // R01
        end
    end

    // Each fine-step register feeds two neighbouring channels.
    assign chanFine[0] = fine_nibble(fine[0], 1'b0); // R15
    assign chanFine[1] = fine_nibble(fine[0], 1'b1); // R15
    assign chanFine[2] = fine_nibble(fine[1], 1'b0); // R15
    assign chanFine[3] = fine_nibble(fine[1], 1'b1); // R15

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            assign chanWeight[ch] = weight[ch][PULSE_W-1:0]; // R14
            assign chanInvert[ch] = weight[ch][WEIGHT_INVERT_BIT]; // R13

            // Weight supplies the top six code bits and fine step the low four.
            prmd_channel u_chan
            (
                .clock      (clock),
                .resetn     (resetn),
                .pulseCount (count[PULSE_W-1:0]), // R16
                .interval   (count[COUNT_W-1:PULSE_W]), // R17
                .weight     (chanWeight[ch]), // R14
                .fineStep   (chanFine[ch]),
                .invert     (chanInvert[ch]), // R13
                .level      (pwmOut[ch])
            );
        end
    endgenerate

    // Write address and data may arrive in either order; both are held
    // until the write is done, and nothing more is taken while a response waits.
    assign awTake      = s_axi_awvalid & s_axi_awready;
    assign wTake       = s_axi_wvalid & s_axi_wready;
    assign haveAw      = awHeld | awTake;
    assign haveW       = wHeld | wTake;
    assign wrDo        = haveAw & haveW & ~s_axi_bvalid;
    assign wrAddr      = awHeld ? awAddr : s_axi_awaddr;
    assign wrByte      = wHeld ? wByte : s_axi_wdata[7:0];
    assign wrLane      = wHeld ? wLane : s_axi_wstrb[0];
    assign wrIndex     = word_index(wrAddr);
    assign wrHit       = is_mapped(wrIndex);
    assign next_awHeld = haveAw & ~wrDo;
    assign next_wHeld  = haveW & ~wrDo;
    assign next_bvalid = wrDo | (s_axi_bvalid & ~s_axi_bready);

    // One select line per register keeps the store process free of decoding.
    assign wrStore     = wrDo & wrLane;
    assign wrWeight[0] = wrStore & (wrIndex == IDX_WEIGHT_CH0);
    assign wrWeight[1] = wrStore & (wrIndex == IDX_WEIGHT_CH1);
    assign wrWeight[2] = wrStore & (wrIndex == IDX_WEIGHT_CH2);
    assign wrWeight[3] = wrStore & (wrIndex == IDX_WEIGHT_CH3);
    assign wrFine[0]   = wrStore & (wrIndex == IDX_FINE_CH1_0);
    assign wrFine[1]   = wrStore & (wrIndex == IDX_FINE_CH3_2);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= '0;
            wByte  <= '0;
            wLane  <= 1'b0;
        end
        else
        begin
            awHeld <= next_awHeld;
            wHeld  <= next_wHeld;
            if (awTake)
            begin
                awAddr <= s_axi_awaddr;
            end
            if (wTake)
            begin
                wByte <= s_axi_wdata[7:0];
                wLane <= s_axi_wstrb[0];
            end
        end
    end

    // Readies come from flip-flops, so each channel rests one cycle after a handshake.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~next_awHeld & ~next_bvalid;
            s_axi_wready  <= ~next_wHeld & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (wrDo)
            begin
                s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Only byte lane 0 carries register data; other lanes are ignored.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            weight[0] <= WEIGHT_RESET[PULSE_W:0]; // R12
            weight[1] <= WEIGHT_RESET[PULSE_W:0];
            weight[2] <= WEIGHT_RESET[PULSE_W:0];
            weight[3] <= WEIGHT_RESET[PULSE_W:0];
            fine[0]   <= FINE_RESET; // R15
            fine[1]   <= FINE_RESET;
        end
        else
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (wrWeight[i])
                begin
                    weight[i] <= wrByte[PULSE_W:0]; // R14 R13
                end
            end
            for (int i = 0; i < FINE_REGS; i++)
            begin
                if (wrFine[i])
                begin
                    fine[i] <= wrByte; // R15
                end
            end
        end
    end

    // Read path: the fixed top bit of every weight register reads as one.
    assign arTake  = s_axi_arvalid & s_axi_arready;
    assign rdIndex = word_index(s_axi_araddr);
    assign rdHit   = is_mapped(rdIndex);

    always_comb
    begin
        rdWord = '0;
        unique case (rdIndex)
            IDX_WEIGHT_CH0: rdWord[7:0] = weight_readback(weight[0]); // R12
            IDX_WEIGHT_CH1: rdWord[7:0] = weight_readback(weight[1]); // R12
            IDX_WEIGHT_CH2: rdWord[7:0] = weight_readback(weight[2]); // R12
            IDX_WEIGHT_CH3: rdWord[7:0] = weight_readback(weight[3]); // R12
            IDX_FINE_CH1_0: rdWord[7:0] = fine[0];
            IDX_FINE_CH3_2: rdWord[7:0] = fine[1];
            IDX_STATUS:
            begin
                rdWord[COUNT_W-1:0] = count;
                rdWord[STATUS_LEVEL_LSB +: CHANNELS] = pwmOut;
            end
            default:
            begin
                rdWord = '0;
            end
        endcase
    end

    // Only one read is ever outstanding, so one state bit is enough.
    always_comb
    begin
        next_rdState = rdState;
        unique case (rdState)
            RS_IDLE:
            begin
                if (arTake)
                begin
                    next_rdState = RS_DATA;
                end
            end
            RS_DATA:
            begin
                if (s_axi_rready)
                begin
                    next_rdState = RS_IDLE;
                end
            end
        endcase
    end

    // Read data are latched at the address edge, so a status read shows the count of that edge.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rdState       <= RS_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            rdState       <= next_rdState;
            s_axi_arready <= (next_rdState == RS_IDLE);
            s_axi_rvalid  <= (next_rdState == RS_DATA);
            if (arTake)
            begin
                s_axi_rdata <= rdWord;
                s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

endmodule

`default_nettype wire
